//--- pkg/cfe_params.svh
// offsets, field layouts, reset values and fixed figures of the front end
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define AXI_AW        16
`define REG_BIAS_IDX  16'h040f
`define ADDR_BIAS     16'h103c
`define ADDR_FE       16'h0000
`define ADDR_SPUR0    16'h0004
`define ADDR_SPUR1    16'h0008
`define ADDR_STATUS   16'h000c

// ----------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------
`define FE_RST        32'h0000_1204
`define FE_MASK       32'h0000_1f1f
`define BIAS_RST      8'h00
`define SPUR_RST      32'h0000_0000
`define SPUR_MASK     32'h003f_ffff

// ----------------------------------------------------------------------
// front end figures
// ----------------------------------------------------------------------
`define BIAS_MV_00    11'd800
`define BIAS_MV_01    11'd400
`define BIAS_MV_10    11'd1600
`define BIAS_MV_11    11'd1200
`define CP_STEP_UA    9'd125
`define CP_CODE_MAX   2'h2
`define N_BIAS        6'd2
`define PRESCALE      7'd2

// ----------------------------------------------------------------------
// spur canceller figures
// ----------------------------------------------------------------------
`define HARM_MIN      4'h2
`define CORR_SHIFT    11
`define DAC_MAX       16'sh1fff
`define DAC_MIN       -16'sh2000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

//--- pkg/cfe_pkg.sv
// types shared by the clock front end and spur canceller
package cfe_pkg;
`include "cfe_params.svh"

    typedef struct packed {
        logic [15:0]        phase;
        logic signed [13:0] sample;
    } dds_word_t;

    typedef struct packed {
        logic [4:0] n_field;
        logic [2:0] spare;
        logic       vco_high;
        logic [1:0] cp_code;
        logic       doubler;
        logic       pd;
    } fe_ctrl_t;

    typedef struct packed {
        logic       gain;
        logic [7:0] amp;
        logic [8:0] phase;
        logic [3:0] harm;
    } spur_cfg_t;

    typedef struct packed {
        logic                    ext1;
        logic                    ext2;
        logic                    aw_got;
        logic                    w_got;
        logic [`AXI_AW-1:0]      waddr;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [31:0]             fe;
        logic [7:0]              bias;
        logic [1:0][31:0]        spur;
        logic [15:0]             prev_ph;
        logic [1:0][15:0]        acc;
        logic [1:0][13:0]        fifo;
        logic                    wp;
        logic                    rp;
        logic [1:0]              cnt;
        logic                    sat;
    } state_t;

endpackage

//--- logic/clock_front_end.sv
// clock front end control and harmonic spur canceller with axi4-lite regs
`timescale 1ns/10ps
`include "cfe_params.svh"

module clock_front_end
    import cfe_pkg::*;
(
    input  wire logic                   aclk,            // 100 MHz
    input  wire logic                   aresetn,         // sync reset
    input  wire logic [`AXI_AW-1:0]     awaddr,          // write addr
    input  wire logic                   awvalid,         // write addr valid
    output logic                        awready,         // write addr ready
    input  wire logic [31:0]            wdata,           // write data
    input  wire logic [3:0]             wstrb,           // byte lanes
    input  wire logic                   wvalid,          // write data valid
    output logic                        wready,          // write data ready
    output logic [1:0]                  bresp,           // write resp
    output logic                        bvalid,          // write resp valid
    input  wire logic                   bready,          // write resp ready
    input  wire logic [`AXI_AW-1:0]     araddr,          // read addr
    input  wire logic                   arvalid,         // read addr valid
    output logic                        arready,         // read addr ready
    output logic [31:0]                 rdata,           // read data
    output logic [1:0]                  rresp,           // read resp
    output logic                        rvalid,          // read valid
    input  wire logic                   rready,          // read ready
    input  wire logic                   crystal_or_external_select_pin, // pin
    input  cfe_pkg::dds_word_t          s_data,          // main core word
    input  wire logic                   s_valid,         // main word valid
    output logic                        s_ready,         // buffer has room
    output logic signed [13:0]          m_data,          // DAC sample
    output logic                        m_valid,         // DAC sample valid
    input  wire logic                   m_ready,         // DAC takes sample
    output logic [1:0]                  bias_code,       // reference bias
    output logic [10:0]                 bias_drop_mv,    // drop below supply
    output logic                        mult_enable,     // multiplier on
    output logic                        xtal_amp_enable, // maintaining amp
    output logic                        sample_clk_direct, // fs = input
    output logic                        doubler_enable,  // input doubler
    output logic                        pfd_falling_edge, // detector edge
    output logic [8:0]                  cp_current_ua,   // pump current
    output logic                        vco_gain_high,   // oscillator gain
    output logic [5:0]                  fb_divide_n,     // actual N
    output logic [6:0]                  fb_ratio         // overall ratio
);
    import cfe_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(logic [31:0] old_v,
                                          logic [31:0] new_v,
                                          logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        return r;
    endfunction

    function automatic logic [10:0] bias_mv(logic [1:0] code);
        logic [10:0] r;
        unique case (code)
            2'h0: r = `BIAS_MV_00;
            2'h1: r = `BIAS_MV_01;
            2'h2: r = `BIAS_MV_10;
            2'h3: r = `BIAS_MV_11;
        endcase
        return r;
    endfunction

    // triangle stands in for the sine table: cheap, but its own
    // harmonics sit far below the 16-lsb correction level anyway
    function automatic logic signed [5:0] corr(spur_cfg_t c,
                                               logic [15:0] acc);
        logic [15:0]        p;
        logic [6:0]         t;
        logic signed [7:0]  tri_v;
        logic signed [16:0] prod;
        logic signed [5:0]  r;
        p = acc + {c.phase, 7'h00};
        t = p[14] ? ~p[13:7] : p[13:7];
        tri_v = p[15] ? -$signed({1'b0, t}) : $signed({1'b0, t});
        prod = tri_v * $signed({1'b0, c.amp});
        r = 6'(prod >>> `CORR_SHIFT);
        if (c.gain)
            r = r <<< 1;
        if (c.harm < `HARM_MIN)
            r = 6'sh00;
        return r;
    endfunction

    // ------------------------------------------------------------------
    // state and derived signals
    // ------------------------------------------------------------------
    state_t             st_r;
    state_t             st_nxt;
    fe_ctrl_t           fe;
    spur_cfg_t [1:0]    cfg;
    logic               fire_in;
    logic               fire_out;
    logic [15:0]        dph;
    logic [1:0][15:0]   acc_n;
    logic signed [5:0]  c0;
    logic signed [5:0]  c1;
    logic signed [15:0] sum_w;
    logic signed [13:0] sum_sat;
    logic [5:0]         n_act;

    assign fe     = fe_ctrl_t'(st_r.fe[12:0]);
    assign cfg[0] = spur_cfg_t'(st_r.spur[0][21:0]);
    assign cfg[1] = spur_cfg_t'(st_r.spur[1][21:0]);

    // ------------------------------------------------------------------
    // front end control
    // ------------------------------------------------------------------
    assign n_act             = 6'({1'b0, fe.n_field} + `N_BIAS);
    assign fb_divide_n       = n_act;
    assign fb_ratio          = `PRESCALE * {1'b0, n_act};
    assign bias_code         = st_r.bias[1:0];
    assign bias_drop_mv      = bias_mv(st_r.bias[1:0]);
    assign mult_enable       = !fe.pd;
    // external mode never touches the multiplier, only the amp
    assign xtal_amp_enable   = !st_r.ext2;
    assign sample_clk_direct = fe.pd;
    assign doubler_enable    = fe.doubler && !fe.pd;
    assign pfd_falling_edge  = 1'b1;
    // code 3 is undefined; pinned to the top level, not wrapped
    assign cp_current_ua     = `CP_STEP_UA *
        ((fe.cp_code > `CP_CODE_MAX) ? 9'd3 : 9'({1'b0, fe.cp_code} + 3'd1));
    assign vco_gain_high     = fe.vco_high;

    // ------------------------------------------------------------------
    // spur canceller datapath
    // ------------------------------------------------------------------
    assign fire_in  = s_valid && s_ready;
    assign fire_out = m_valid && m_ready;
    assign dph      = s_data.phase - st_r.prev_ph;

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_ch
            assign acc_n[i] = st_r.acc[i] + 16'(dph * cfg[i].harm);
        end
    endgenerate

    assign c0    = corr(cfg[0], acc_n[0]);
    assign c1    = corr(cfg[1], acc_n[1]);
    assign sum_w = 16'(s_data.sample) + 16'(c0) + 16'(c1);
    assign sum_sat = (sum_w > `DAC_MAX) ? 14'(`DAC_MAX) :
                     (sum_w < `DAC_MIN) ? 14'(`DAC_MIN) : 14'(sum_w);

    // ------------------------------------------------------------------
    // bus handshakes and buffer outputs
    // ------------------------------------------------------------------
    assign awready = !st_r.aw_got && !st_r.bvalid;
    assign wready  = !st_r.w_got && !st_r.bvalid;
    assign bvalid  = st_r.bvalid;
    assign bresp   = st_r.bresp;
    assign arready = !st_r.rvalid;
    assign rvalid  = st_r.rvalid;
    assign rdata   = st_r.rdata;
    assign rresp   = st_r.rresp;
    assign s_ready = (st_r.cnt != 2'h2);
    assign m_valid = (st_r.cnt != 2'h0);
    assign m_data  = st_r.fifo[st_r.rp];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // first stage feeds only the second
        st_nxt.ext1 = crystal_or_external_select_pin;
        st_nxt.ext2 = st_r.ext1;

        if (awvalid && awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.waddr  = awaddr;
        end
        if (wvalid && wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (st_r.bvalid && bready)
            st_nxt.bvalid = 1'b0;
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = `RESP_OKAY;
            unique case (st_r.waddr)
                `ADDR_FE:
                    st_nxt.fe = merge(st_r.fe, st_r.wdata, st_r.wstrb)
                                & `FE_MASK;
                `ADDR_BIAS:
                    st_nxt.bias = st_r.wstrb[0] ? st_r.wdata[7:0]
                                                : st_r.bias;
                `ADDR_SPUR0:
                    st_nxt.spur[0] = merge(st_r.spur[0], st_r.wdata,
                                           st_r.wstrb) & `SPUR_MASK;
                `ADDR_SPUR1:
                    st_nxt.spur[1] = merge(st_r.spur[1], st_r.wdata,
                                           st_r.wstrb) & `SPUR_MASK;
                `ADDR_STATUS:
                    st_nxt.bresp = `RESP_OKAY;
                default:
                    st_nxt.bresp = `RESP_SLVERR;
            endcase
        end

        if (st_r.rvalid && rready)
            st_nxt.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = `RESP_OKAY;
            unique case (araddr)
                `ADDR_FE:     st_nxt.rdata = st_r.fe;
                `ADDR_BIAS:   st_nxt.rdata = {24'h0, st_r.bias};
                `ADDR_SPUR0:  st_nxt.rdata = st_r.spur[0];
                `ADDR_SPUR1:  st_nxt.rdata = st_r.spur[1];
                `ADDR_STATUS: st_nxt.rdata = {13'h0, st_r.sat, st_r.ext2,
                                              mult_enable, 1'b0, fb_ratio,
                                              2'h0, n_act};
                default:
                begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rresp = `RESP_SLVERR;
                end
            endcase
        end

        // accumulators advance only on taken words, so a stall
        // freezes the correction phase together with the main core
        if (fire_in)
        begin
            st_nxt.prev_ph         = s_data.phase;
            st_nxt.acc             = acc_n;
            st_nxt.fifo[st_r.wp]   = sum_sat;
            st_nxt.wp              = !st_r.wp;
            st_nxt.sat             = (14'(sum_w) != sum_sat) ||
                                     (sum_w > `DAC_MAX) || (sum_w < `DAC_MIN);
        end
        if (fire_out)
            st_nxt.rp = !st_r.rp;
        unique case ({fire_in, fire_out})
            2'b10:   st_nxt.cnt = st_r.cnt + 2'h1;
            2'b01:   st_nxt.cnt = st_r.cnt - 2'h1;
            default: st_nxt.cnt = st_r.cnt;
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r         <= '0;
            st_r.fe      <= `FE_RST;
            st_r.bias    <= `BIAS_RST;
            st_r.spur[0] <= `SPUR_RST;
            st_r.spur[1] <= `SPUR_RST;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bias_table: assert property (
        (bias_code == 2'h2) |-> (bias_drop_mv == 11'd1600))
        else $error("bias code 10 not 1600 mV");

    a_mult_path: assert property (
        mult_enable != sample_clk_direct)
        else $error("multiplier and bypass disagree");

    a_ext_amp_off: assert property (
        crystal_or_external_select_pin [*3] |-> !xtal_amp_enable)
        else $error("amp still on in external mode");

    a_bypass_src: assert property (
        $rose(st_r.fe[0]) |-> sample_clk_direct && !doubler_enable)
        else $error("bypass not taken from input");

    a_cp_level: assert property (
        cp_current_ua inside {9'd125, 9'd250, 9'd375})
        else $error("pump current off grid");

    a_fb_ratio: assert property (
        fb_ratio == 7'(2 * (st_r.fe[12:8] + 2)) && fb_ratio >= 7'd4
        && fb_ratio <= 7'd66 && !fb_ratio[0])
        else $error("feedback ratio wrong");

    a_reset_forty: assert property (
        $past(!aresetn) |-> fb_ratio == 7'd40 && mult_enable)
        else $error("reset ratio not forty");

    a_harm_off: assert property (
        (cfg[0].harm < 4'h2) |-> (c0 == 6'sh00))
        else $error("disabled channel leaks");

    a_gain_shift: assert property (
        cfg[1].gain && cfg[1].harm >= 4'h2 |-> !c1[0])
        else $error("gain bit did not shift");

    a_sat_clip: assert property (
        fire_in && sum_w > 16'sh1fff |=> st_r.sat)
        else $error("overflow not saturated");

    a_stall_hold: assert property (
        m_valid && !m_ready |=> m_valid && $stable(m_data))
        else $error("stalled sample lost");

endmodule // clock_front_end

//--- tb/dac_sink.sv
// dac-side sink model that collects converted samples and stalls on command
`timescale 1ns/10ps

module dac_sink
(
    input  wire logic               aclk,    // sample clock
    input  wire logic               aresetn, // sync reset, active low
    input  wire logic signed [13:0] m_data,  // sample from the block
    input  wire logic               m_valid, // sample valid
    output logic                    m_ready, // sink takes sample
    input  wire logic               stall    // bench holds the sink off
);
    logic signed [13:0] mem [0:15];
    int                 cnt;

    // ----------------------------------------------------------------
    // capture
    // ----------------------------------------------------------------
    // ready follows only the stall command, never the valid
    assign m_ready = !stall;

    always @(posedge aclk)
    begin
        if (!aresetn)
            cnt <= 0;
        else if (m_valid && m_ready)
        begin
            mem[cnt[3:0]] <= m_data;
            cnt           <= cnt + 1;
        end
    end
endmodule // dac_sink

//--- tb/tb.sv
// self-checking bench for the clock front end and spur canceller
`timescale 1ns/10ps
`include "cfe_params.svh"
`define CHK(g, e) begin samples_checked++; \
    if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module tb;
    import cfe_pkg::*;

    logic               aclk = 0, aresetn = 0, pin = 0, stall = 1;
    logic [15:0]        awaddr = '0, araddr = '0;
    logic [31:0]        wdata = '0, rdata, rd, w;
    logic [3:0]         wstrb = '0;
    logic [1:0]         bresp, rresp, rs;
    logic               awvalid = 0, wvalid = 0, bready = 0, ok;
    logic               arvalid = 0, rready = 0, awready, wready;
    logic               bvalid, arready, rvalid, s_valid = 0, s_ready;
    logic               m_valid, m_ready, mult_enable, xtal_amp_enable;
    logic               sample_clk_direct, doubler_enable, vco_gain_high;
    logic               pfd_falling_edge;
    dds_word_t          s_data = '0;
    logic signed [13:0] m_data, v;
    logic [1:0]         bias_code;
    logic [10:0]        bias_drop_mv;
    logic [8:0]         cp_current_ua;
    logic [5:0]         fb_divide_n;
    logic [6:0]         fb_ratio;
    int                 n_errors = 0, samples_checked = 0, i, f;
    logic [10:0]        mv [4] = '{11'd800, 11'd400, 11'd1600, 11'd1200};

    always #5 aclk = ~aclk;

    clock_front_end clock_front_end_i
    (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready,
        .crystal_or_external_select_pin (pin),
        .s_data, .s_valid, .s_ready, .m_data, .m_valid, .m_ready,
        .bias_code, .bias_drop_mv, .mult_enable, .xtal_amp_enable,
        .sample_clk_direct, .doubler_enable, .pfd_falling_edge,
        .cp_current_ua, .vco_gain_high, .fb_divide_n, .fb_ratio
    );

    dac_sink dac_sink_i
    (
        .aclk, .aresetn, .m_data, .m_valid, .m_ready, .stall
    );

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic test_done;
    begin
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    task automatic tmo(input int k);
    begin
        if (k >= 64)
        begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            test_done();
        end
    end
    endtask

    task automatic wreg(input logic [15:0] a, input logic [31:0] d,
                        output logic [1:0] r);
        int k;
    begin
        // one edge between calls keeps bready from toggling in one step
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        r = bresp;
        bready <= 1'b0;
        tmo(k);
    end
    endtask

    task automatic rreg(input logic [15:0] a, output logic [31:0] d,
                        output logic [1:0] r);
        int k;
    begin
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        tmo(k);
    end
    endtask

    // holds the word until an edge samples s_ready high
    task automatic send(input logic signed [13:0] s, input logic [15:0] p);
        int k;
    begin
        s_data  <= '{phase: p, sample: s};
        s_valid <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (s_ready)
                break;
        end
        tmo(k);
    end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(fb_ratio, 7'd40)
        `CHK(fb_divide_n, 6'd20)
        `CHK(mult_enable, 1'b1)
        `CHK(xtal_amp_enable, 1'b1)
        rreg(`ADDR_FE, rd, rs);
        `CHK(rd, 32'h0000_1204)
        rreg(`ADDR_STATUS, rd, rs);
        `CHK(rd, 32'h0001_2814)
        for (i = 0; i < 4; i++)
        begin
            wreg(`ADDR_BIAS, i, rs);
            @(posedge aclk);
            `CHK(bias_code, i[1:0])
            `CHK(bias_drop_mv, mv[i])
            `CHK(rs, 2'h0)
        end
        // divider field ends 0 and 31, pump codes 0 to 2
        for (i = 0; i < 3; i++)
        begin
            f = (i == 0) ? 0 : (i == 1) ? 31 : 7;
            w = {19'h0, f[4:0], 3'h0, i[0], i[1:0], 1'b1, 1'b0};
            wreg(`ADDR_FE, w, rs);
            @(posedge aclk);
            `CHK(cp_current_ua, 9'(125 * (i + 1)))
            `CHK(vco_gain_high, i[0])
            `CHK(doubler_enable, 1'b1)
            `CHK(pfd_falling_edge, 1'b1)
            `CHK(fb_divide_n, 6'(f + 2))
            `CHK(fb_ratio, 7'(2 * (f + 2)))
            rreg(`ADDR_FE, rd, rs);
            `CHK(rd, w)
        end
        wreg(`ADDR_FE, 32'h0000_1203, rs);
        @(posedge aclk);
        `CHK(mult_enable, 1'b0)
        `CHK(sample_clk_direct, 1'b1)
        `CHK(doubler_enable, 1'b0)
        wreg(`ADDR_FE, 32'h0000_120c, rs);
        @(posedge aclk);
        `CHK(cp_current_ua, 9'd375)
        wreg(`ADDR_FE, 32'h0000_1204, rs);
        pin <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(xtal_amp_enable, 1'b0)
        `CHK(mult_enable, 1'b1)
        rreg(`ADDR_STATUS, rd, rs);
        `CHK(rd, 32'h0003_2814)
        pin <= 1'b0;
        // unmapped place and the read-only status word
        wreg(16'h0200, 32'hffff_ffff, rs);
        `CHK(rs, 2'h2)
        rreg(16'h0200, rd, rs);
        `CHK(rs, 2'h2)
        `CHK(rd, 32'h0)
        wreg(`ADDR_STATUS, 32'h0, rs);
        `CHK(rs, 2'h0)
        `CHK(xtal_amp_enable, 1'b1)
        // sink stalled since reset: two words fill the buffer
        send(14'sd100, 16'h0);
        send(-14'sd5, 16'h0);
        s_valid <= 1'b0;
        @(posedge aclk);
        `CHK(s_ready, 1'b0)
        `CHK(m_valid, 1'b1)
        stall <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(dac_sink_i.mem[0], 14'sd100)
        `CHK(dac_sink_i.mem[1], -14'sd5)
        // both channels at full strength against full-scale samples
        wreg(`ADDR_SPUR0, 32'h003f_e003, rs);
        wreg(`ADDR_SPUR1, 32'h003f_e00f, rs);
        rreg(`ADDR_SPUR1, rd, rs);
        `CHK(rd, 32'h003f_e00f)
        for (i = 0; i < 8; i++)
            send(i[0] ? 14'h2000 : 14'h1fff, 16'(i * 16'h1357));
        s_valid <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(dac_sink_i.cnt, 10)
        for (i = 0; i < 8; i++)
        begin
            v  = dac_sink_i.mem[i + 2];
            ok = i[0] ? (v <= -14'sd8130) : (v >= 14'sd8130);
            `CHK(ok, 1'b1)
        end
        // last word was clipped, so the status level reads set
        rreg(`ADDR_STATUS, rd, rs);
        `CHK(rd, 32'h0005_2814)
        test_done();
    end
endmodule // tb
